/* File: hw/cof_formatter.sv */
/*
  cof_formatter: APB-programmed character output formatter. Per purpose device selection
  and line length, line counters with automatic return, zoned elements, display roll and
  queued end-of-statement return, feeding one peripheral output port.
  Assumes an APB master on ref_clk and a peripheral with a strobe and busy handshake.
*/
`timescale 1ns/1ps
// Function
// - codes 00 to 0F go out but move neither cursor nor line counter.
// - each printable character advances the cursor and line counter by one.
// - error, stop and end messages always go to the console output purpose.
// - immediate mode print output goes to the console output purpose.
// - statements queue a return; emitted at program end or step completion.
// - an element not fitting the rest of its zone starts whole on the next line, unless already at line start.
// - passing sixteen display lines rolls the display up one line.
// - every roll produces its own carriage return plus line feed.
// - each purpose holds one device; the later selection wins.
// - one selection may set several purposes, all to the same device and length.
// - a printable character arriving with the counter at line length forces a return first, clears counter, continues.
// - reset sets every line length to 64; lengths up to 255.
// - type 4 drops the automatic return but keeps end-of-line returns.
// - type 0 adds a line feed after every generated return.
module cof_formatter
  import cof_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYC,
  parameter int GUARD_LEN  = GUARD_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              devBusy,
  output cof_pkg::cof_txreq_s    devOut,
  output logic                   devStrobe,
  output logic                   rollPulse
);

  typedef struct packed {
    cof_sel_s [NUM_PURPOSE-1:0]   sel;
    logic [NUM_PURPOSE-1:0][7:0]  cnt;
    logic [3:0]                   lineNo;
    logic                         pendCr;
    logic                         pendLf;
    logic                         pendChar;
    logic [7:0]                   curChar;
    logic [1:0]                   curP;
    logic                         crlfQueued;
    logic                         stepMode;
    logic                         txValid;
    cof_txreq_s                   txReq;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic                         rollPulse;
  } cof_main_s;

  cof_main_s s;
  cof_main_s next_s;

  logic        txReady;
  logic        apbReq;
  logic        engBusy;
  logic        hit;
  logic [31:0] rdWord;
  logic [7:0]  dChar;
  cof_src_e    dSrc;
  logic [1:0]  dKind;
  logic [7:0]  dElen;
  logic [1:0]  dPur;
  logic [7:0]  zoneRem;

  // source of a character decides which purpose's device receives it
  function automatic logic [1:0] purpose_of(input cof_src_e src);
    case (src)
      SRC_PROG_PRINT: purpose_of = PUR_PRINT;
      SRC_IMM_PRINT:  purpose_of = PUR_CON;
      SRC_MESSAGE:    purpose_of = PUR_CON;
      SRC_LIST:       purpose_of = PUR_LIST;
      default:        purpose_of = PUR_CON;
    endcase
  endfunction : purpose_of

  // unpack a selection word; the struct is narrower than the word, so fields go one by one
  function automatic cof_sel_s sel_field(input logic [31:0] w);
    cof_sel_s v;
    v.devAddr = w[SEL_ADDR_LSB +: 8];
    v.devType = w[SEL_TYPE_LSB +: 4];
    v.lineLen = w[SEL_LEN_LSB +: 8];
    return v;
  endfunction : sel_field

  // pack one purpose's selection back into its register layout, spare bits read zero
  function automatic logic [31:0] sel_word(input cof_sel_s v);
    logic [31:0] w;
    w                    = 32'h0000_0000;
    w[SEL_ADDR_LSB +: 8] = v.devAddr;
    w[SEL_TYPE_LSB +: 4] = v.devType;
    w[SEL_LEN_LSB +: 8]  = v.lineLen;
    return w;
  endfunction : sel_word

  // schedule a generated return on purpose p, clearing its counter
  function automatic cof_main_s take_newline(input cof_main_s st, input logic [1:0] p,
                                             input logic forceLf);
    cof_main_s r;
    r        = st;
    r.curP   = p;
    r.pendCr = 1'b1;
    r.pendLf = forceLf || (st.sel[p].devType == TYPE_DOUBLE);
    r.cnt[p] = 8'h00;
    if (p == PUR_CON) begin
      if (st.lineNo == LAST_LINE) begin
        r.rollPulse = 1'b1;
        r.pendLf    = 1'b1;
      end else begin
        r.lineNo = st.lineNo + 4'h1;
      end
    end
    return r;
  endfunction : take_newline

  // field extraction of the data word
  always_comb begin
    dChar   = pwdata[DATA_CHAR_LSB +: 8];
    dSrc    = cof_src_e'(pwdata[DATA_SRC_LSB +: 3]);
    dKind   = pwdata[DATA_KIND_LSB +: 2];
    dElen   = pwdata[DATA_ELEN_LSB +: 8];
    dPur    = purpose_of(dSrc);
    zoneRem = ZONE_WIDTH - (s.cnt[dPur] & ZONE_MASK);
    apbReq  = psel && penable && !s.pready;
    engBusy = s.pendCr || s.pendLf || s.pendChar || s.txValid;
  end

  // read mux; unmapped offsets read zero with an error
  always_comb begin
    hit    = 1'b1;
    rdWord = 32'h0000_0000;
    case (paddr)
      ADDR_SEL_LIST:  rdWord = sel_word(s.sel[PUR_LIST]);
      ADDR_SEL_PRINT: rdWord = sel_word(s.sel[PUR_PRINT]);
      ADDR_SEL_CON:   rdWord = sel_word(s.sel[PUR_CON]);
      ADDR_SEL_MULTI: rdWord = 32'h0000_0000;
      ADDR_DATA:      rdWord = {24'h00_0000, s.curChar};
      ADDR_CTRL:      rdWord = {28'h000_0000, s.stepMode, 3'h0};
      ADDR_STATUS:    rdWord = {24'h00_0000, s.lineNo, s.crlfQueued, s.curP, engBusy};
      ADDR_COUNT:     rdWord = {8'h00, s.cnt[PUR_CON], s.cnt[PUR_PRINT], s.cnt[PUR_LIST]};
      default:        hit    = 1'b0;
    endcase
  end

  // bus slave, command handling and character issue
  always_comb begin
    next_s           = s;
    next_s.pready    = 1'b0;
    next_s.pslverr   = 1'b0;
    next_s.txValid   = 1'b0;
    next_s.rollPulse = 1'b0;

    // issue one pending byte; return, then feed, then the character
    if (txReady && !s.txValid) begin
      if (s.pendCr) begin
        next_s.pendCr  = 1'b0;
        next_s.txValid = 1'b1;
        next_s.txReq   = '{data: CHAR_CR, addr: s.sel[s.curP].devAddr};
      end else if (s.pendLf) begin
        next_s.pendLf  = 1'b0;
        next_s.txValid = 1'b1;
        next_s.txReq   = '{data: CHAR_LF, addr: s.sel[s.curP].devAddr};
      end else if (s.pendChar) begin
        next_s.pendChar = 1'b0;
        next_s.txValid  = 1'b1;
        next_s.txReq    = '{data: s.curChar, addr: s.sel[s.curP].devAddr};
        // control codes are sent but leave the counter alone
        if (s.curChar >= PRINTABLE_MIN) begin
          next_s.cnt[s.curP] = s.cnt[s.curP] + 8'h01;
        end
      end
    end

    if (apbReq) begin
      if (!pwrite) begin
        next_s.pready  = 1'b1;
        next_s.prdata  = rdWord;
        next_s.pslverr = !hit;
      end else begin
        case (paddr)
          ADDR_SEL_LIST, ADDR_SEL_PRINT, ADDR_SEL_CON: begin
            // a later write simply overwrites the one device of that purpose
            next_s.pready = 1'b1;
            next_s.sel[paddr[3:2]] = sel_field(pwdata);
          end
          ADDR_SEL_MULTI: begin
            next_s.pready = 1'b1;
            for (int i = 0; i < NUM_PURPOSE; i++) begin
              if (pwdata[MULTI_MASK_LSB + i]) begin
                next_s.sel[i] = sel_field(pwdata);
              end
            end
          end
          ADDR_DATA: begin
            // held in the access phase while earlier output drains
            if (!engBusy) begin
              next_s.pready  = 1'b1;
              next_s.curP    = dPur;
              next_s.curChar = dChar;
              case (dKind)
                KIND_LINE_END: begin
                  // end-of-line return goes out whatever the device type
                  next_s = take_newline(next_s, dPur, 1'b0);
                end
                KIND_ELEMENT: begin
                  if (s.cnt[dPur] != 8'h00 && dElen > zoneRem) begin
                    next_s = take_newline(next_s, dPur, 1'b0);
                  end
                end
                KIND_CHAR: begin
                  if (dChar >= PRINTABLE_MIN && s.sel[dPur].lineLen != 8'h00 &&
                      s.cnt[dPur] == s.sel[dPur].lineLen) begin
                    if (s.sel[dPur].devType == TYPE_NO_AUTO) begin
                      next_s.cnt[dPur] = 8'h00;
                    end else begin
                      next_s = take_newline(next_s, dPur, 1'b0);
                    end
                  end
                  next_s.pendChar = 1'b1;
                end
                default: begin
                  next_s.pendChar = 1'b0;
                end
              endcase
            end
          end
          ADDR_CTRL: begin
            if (!engBusy) begin
              next_s.pready   = 1'b1;
              next_s.stepMode = pwdata[CTRL_STEP_MODE];
              if (pwdata[CTRL_CLEAR]) begin
                next_s.cnt        = '0;
                next_s.lineNo     = 4'h0;
                next_s.crlfQueued = 1'b0;
              end
              // a statement executed in the same write still queues its return
              if (pwdata[CTRL_STMT_EXEC]) begin
                next_s.crlfQueued = 1'b1;
              end
              if ((s.crlfQueued || pwdata[CTRL_STMT_EXEC]) &&
                  (pwdata[CTRL_PROG_DONE] ||
                   (pwdata[CTRL_STMT_DONE] && pwdata[CTRL_STEP_MODE]))) begin
                next_s            = take_newline(next_s, PUR_CON, 1'b1);
                next_s.crlfQueued = 1'b0;
              end
            end
          end
          ADDR_STATUS, ADDR_COUNT: begin
            next_s.pready = 1'b1;
          end
          default: begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  // every purpose starts at the default device and line length
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      for (int i = 0; i < NUM_PURPOSE; i++) begin
        s.sel[i] <= '{devAddr: DEV_ADDR_RST, devType: DEV_TYPE_RST, lineLen: LINE_LEN_RST};
      end
    end else begin
      s <= next_s;
    end
  end

  cof_out_port #(
    .STROBE_LEN (STROBE_LEN),
    .GUARD_LEN  (GUARD_LEN)
  ) u_out (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .reqValid  (s.txValid),
    .reqData   (s.txReq),
    .reqReady  (txReady),
    .devBusy   (devBusy),
    .devOut    (devOut),
    .devStrobe (devStrobe)
  );

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign rollPulse = s.rollPulse;

endmodule : cof_formatter

/* File: hw/cof_out_port.sv */
/*
  cof_out_port: drives one character at a time to the peripheral with a strobe and waits
  for the peripheral busy pin to fall.
  Assumes devBusy is asynchronous to ref_clk and rises within the guard time after strobe.
*/
`timescale 1ns/1ps
module cof_out_port
  import cof_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYC,
  parameter int GUARD_LEN  = GUARD_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              reqValid,
  input  cof_pkg::cof_txreq_s    reqData,
  output logic                   reqReady,
  input  wire logic              devBusy,
  output cof_pkg::cof_txreq_s    devOut,
  output logic                   devStrobe
);

  typedef struct packed {
    cof_tx_e    st;
    logic       busyMeta;
    logic       busySync;
    logic [7:0] timer;
    cof_txreq_s hold;
    logic       strobe;
  } cof_tx_s;

  cof_tx_s s;
  cof_tx_s next_s;

  // strobe, then guard, then wait for busy to clear
  always_comb begin
    next_s          = s;
    next_s.busyMeta = devBusy;
    next_s.busySync = s.busyMeta;
    case (s.st)
      TX_IDLE: begin
        if (reqValid) begin
          next_s.hold   = reqData;
          next_s.strobe = 1'b1;
          next_s.timer  = 8'(STROBE_LEN - 1);
          next_s.st     = TX_STROBE;
        end
      end
      TX_STROBE: begin
        if (s.timer == 8'h00) begin
          next_s.strobe = 1'b0;
          next_s.timer  = 8'(GUARD_LEN - 1);
          next_s.st     = TX_WAIT;
        end else begin
          next_s.timer = s.timer - 8'h01;
        end
      end
      TX_WAIT: begin
        // guard covers the pin's synchroniser latency before trusting busy low
        if (s.timer != 8'h00) begin
          next_s.timer = s.timer - 8'h01;
        end else if (!s.busySync) begin
          next_s.st = TX_IDLE;
        end
      end
      default: begin
        next_s.st     = TX_IDLE;
        next_s.strobe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reqReady  = (s.st == TX_IDLE);
  assign devOut    = s.hold;
  assign devStrobe = s.strobe;

endmodule : cof_out_port

/* File: hw/cof_pkg.sv */
/*
  cof_pkg: register map, field positions, reset values, codes, timing counts and carrier
  structs of the console output formatter.
  Assumes a 200 MHz ref_clk. All offsets are byte addresses on a 32-bit APB.
*/
package cof_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_SEL_LIST  = 8'h00;
  localparam logic [7:0] ADDR_SEL_PRINT = 8'h04;
  localparam logic [7:0] ADDR_SEL_CON   = 8'h08;
  localparam logic [7:0] ADDR_SEL_MULTI = 8'h0C;
  localparam logic [7:0] ADDR_DATA      = 8'h10;
  localparam logic [7:0] ADDR_CTRL      = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_COUNT     = 8'h1C;

  // selection word fields (per purpose and multi-select)
  localparam int SEL_LEN_LSB    = 0;
  localparam int SEL_TYPE_LSB   = 8;
  localparam int SEL_ADDR_LSB   = 16;
  localparam int MULTI_MASK_LSB = 24;

  // data word fields
  localparam int DATA_CHAR_LSB = 0;
  localparam int DATA_SRC_LSB  = 8;
  localparam int DATA_KIND_LSB = 12;
  localparam int DATA_ELEN_LSB = 16;

  // control word bits
  localparam int CTRL_STMT_EXEC = 0;
  localparam int CTRL_STMT_DONE = 1;
  localparam int CTRL_PROG_DONE = 2;
  localparam int CTRL_STEP_MODE = 3;
  localparam int CTRL_CLEAR     = 4;

  // output purposes
  localparam int         NUM_PURPOSE = 3;
  localparam logic [1:0] PUR_LIST    = 2'h0;
  localparam logic [1:0] PUR_PRINT   = 2'h1;
  localparam logic [1:0] PUR_CON     = 2'h2;

  // values after reset
  localparam logic [7:0] LINE_LEN_RST = 8'h40;
  localparam logic [3:0] DEV_TYPE_RST = 4'h0;
  localparam logic [7:0] DEV_ADDR_RST = 8'h05;

  // character and device codes
  localparam logic [7:0] PRINTABLE_MIN = 8'h10;
  localparam logic [7:0] CHAR_CR       = 8'h0D;
  localparam logic [7:0] CHAR_LF       = 8'h0A;
  localparam logic [7:0] ZONE_WIDTH    = 8'h10;
  localparam logic [7:0] ZONE_MASK     = 8'h0F;
  localparam logic [3:0] LAST_LINE     = 4'hF;
  localparam logic [3:0] TYPE_DOUBLE   = 4'h0;
  localparam logic [3:0] TYPE_NO_AUTO  = 4'h4;

  // peripheral strobe timing
  localparam int CLK_MHZ    = 200;
  localparam int STROBE_NS  = 20;
  localparam int GUARD_NS   = 10;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int GUARD_CYC  = (GUARD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SRC_PROG_PRINT = 3'b000,
    SRC_IMM_PRINT  = 3'b001,
    SRC_MESSAGE    = 3'b010,
    SRC_LIST       = 3'b011,
    SRC_CON_ECHO   = 3'b100
  } cof_src_e;

  typedef enum logic [1:0] {
    KIND_CHAR     = 2'b00,
    KIND_LINE_END = 2'b01,
    KIND_ELEMENT  = 2'b10
  } cof_kind_e;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_STROBE = 2'b01,
    TX_WAIT   = 2'b10
  } cof_tx_e;

  typedef struct packed {
    logic [7:0] devAddr;
    logic [3:0] devType;
    logic [7:0] lineLen;
  } cof_sel_s;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr;
  } cof_txreq_s;

endpackage : cof_pkg

/* File: tb/cof_formatter_assertions.sv */
/* cof_formatter_assertions: bus, strobe and roll checks on the formatter ports.
   Assumes it is bound onto cof_formatter; one clock, rst async high. */
`timescale 1ns/1ps
module cof_formatter_assertions
  import cof_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYC,
  parameter int GUARD_LEN  = GUARD_CYC
) (
  input logic                ref_clk,
  input logic                rst,
  input logic                psel,
  input logic                penable,
  input logic                pwrite,
  input logic [7:0]          paddr,
  input logic                pready,
  input logic                pslverr,
  input cof_pkg::cof_txreq_s devOut,
  input logic                devStrobe,
  input logic                rollPulse
);
  int hiLen;
  int loLen;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // run lengths of strobe high and low; low saturates so idles never wrap
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hiLen <= 0;
      loLen <= 100;
    end else begin
      hiLen <= devStrobe ? hiLen + 1 : 0;
      loLen <= devStrobe ? 0 : (loLen < 100 ? loLen + 1 : loLen);
    end
  end
  sequence s_lf_out;
    $rose(devStrobe) && devOut.data == CHAR_LF;
  endsequence
  sequence s_read_start;
    psel && penable && !pwrite && !$past(penable);
  endsequence
  a_strobe_width: assert property ($fell(devStrobe) |-> hiLen == STROBE_LEN)
    else $error("strobe width wrong");
  a_guard_gap: assert property ($rose(devStrobe) |-> loLen >= GUARD_LEN)
    else $error("strobe guard too short");
  a_out_steady: assert property (devStrobe && $past(devStrobe) |-> $stable(devOut))
    else $error("output byte moved during strobe");
  a_roll_single: assert property (rollPulse |=> !rollPulse)
    else $error("roll pulse too long");
  a_roll_crlf: assert property (rollPulse |-> ##[0:300] s_lf_out)
    else $error("roll without line feed");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_read_answer: assert property (s_read_start |=> pready)
    else $error("read answer late");
  a_err_decode: assert property (pready |-> pslverr == (paddr > ADDR_COUNT || paddr[1:0] != 2'h0))
    else $error("error response wrong");
endmodule : cof_formatter_assertions

bind cof_formatter cof_formatter_assertions #(
  .STROBE_LEN(STROBE_LEN),
  .GUARD_LEN (GUARD_LEN)
) u_chk (
  .ref_clk  (ref_clk),
  .rst      (rst),
  .psel     (psel),
  .penable  (penable),
  .pwrite   (pwrite),
  .paddr    (paddr),
  .pready   (pready),
  .pslverr  (pslverr),
  .devOut   (devOut),
  .devStrobe(devStrobe),
  .rollPulse(rollPulse)
);

/* File: tb/cof_printer_model.sv */
/* cof_printer_model: far-side peripheral; goes busy on each strobe for a
   short or long print time. Assumes strobes from the formatter on ref_clk. */
`timescale 1ns/1ps
module cof_printer_model (
  input  logic ref_clk,
  input  logic rst,
  input  logic devStrobe,
  input  logic slow,
  output logic devBusy
);
  logic prevStb;
  int   left;
  // busy starts the cycle after strobe rises, while strobe is still high, before the guard
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevStb <= 1'b0;
      left    <= 0;
    end else begin
      prevStb <= devStrobe;
      if (devStrobe && !prevStb)
        left <= slow ? 12 : 1;
      else if (left > 0 && !devStrobe)
        left <= left - 1;
    end
  end
  assign devBusy = (left != 0);
endmodule : cof_printer_model

/* File: tb/testbench.sv */
/* testbench: drives the formatter over APB, predicts peripheral bytes,
   counts and rolls, and compares. Assumes the bound checker and model. */
`timescale 1ns/1ps
module testbench;
  import cof_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        slow    = 1'b0;
  logic        prevStb = 1'b0;
  logic        q       = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        devBusy;
  logic        devStrobe;
  logic        rollPulse;
  cof_txreq_s  devOut;
  logic [31:0] rd;
  logic        er;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          seed       = 32'h26DD751D;
  int          rolls      = 0;
  int          erolls     = 0;
  int          ln         = 0;
  int          cnt [3]    = '{0, 0, 0};
  logic [7:0]  len [3]    = '{8'h40, 8'h40, 8'h40};
  logic [3:0]  typ [3]    = '{4'h0, 4'h0, 4'h0};
  logic [7:0]  adr [3]    = '{8'h05, 8'h05, 8'h05};
  logic [3:0]  tl [3]     = '{4'h2, 4'h4, 4'h0};
  logic [15:0] got [$];
  logic [15:0] want [$];

  always #2.5 ref_clk = ~ref_clk;

  cof_formatter i_cof_formatter (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .devBusy(devBusy),
    .devOut(devOut), .devStrobe(devStrobe), .rollPulse(rollPulse));
  cof_printer_model i_cof_printer_model (.ref_clk(ref_clk), .rst(rst),
    .devStrobe(devStrobe), .slow(slow), .devBusy(devBusy));

  // byte capture at each strobe rise, plus roll count
  always @(posedge ref_clk) begin
    prevStb <= devStrobe;
    if (devStrobe === 1'b1 && prevStb === 1'b0)
      got.push_back(devOut);
    if (rollPulse === 1'b1)
      rolls++;
  end

  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one APB transfer; entered just after a rising edge, sampled at the rising
  // edge that sees pready, then one idle edge so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  function automatic void push(input int p, input logic [7:0] c);
    want.push_back({c, adr[p]});
  endfunction : push

  // predicted newline; console rolls instead of moving past line 15
  function automatic void nl(input int p, input logic f);
    logic roll;
    roll = (p == 2 && ln == 15);
    push(p, CHAR_CR);
    if (typ[p] == TYPE_DOUBLE || f || roll)
      push(p, CHAR_LF);
    if (roll)
      erolls++;
    else if (p == 2)
      ln++;
    cnt[p] = 0;
  endfunction : nl

  function automatic logic [7:0] pick(input int i);
    logic [7:0] r;
    r = 8'($random(seed));
    if (i == 0)
      return 8'h0F;
    if (i == 1)
      return 8'h10;
    if (i % 4 == 3)
      return r & 8'h0F;
    return 8'h20 | (r & 8'h5F);
  endfunction : pick

  task automatic sel(input int p, input logic [7:0] a, input logic [3:0] t, input logic [7:0] l);
    adr[p] = a;
    typ[p] = t;
    len[p] = l;
    apb(1'b1, 8'(4 * p), {8'h00, a, 4'h0, t, l});
    apb(1'b0, 8'(4 * p), 32'h0);
    chk(rd, {8'h00, a, 4'h0, t, l});
  endtask : sel

  // predict the bytes of one data word, then write it
  task automatic send(input logic [2:0] s, input logic [1:0] k, input logic [7:0] c,
                      input logic [7:0] el);
    int p;
    p = (s == 3'h0) ? 1 : (s == 3'h3) ? 0 : 2;
    if (k == 2'h1)
      nl(p, 1'b0);
    else if (k == 2'h2 && cnt[p] != 0 && el > 16 - cnt[p] % 16)
      nl(p, 1'b0);
    else if (k == 2'h0 && c < PRINTABLE_MIN)
      push(p, c);
    else if (k == 2'h0) begin
      if (len[p] != 0 && cnt[p] == len[p] && typ[p] == TYPE_NO_AUTO)
        cnt[p] = 0;
      else if (len[p] != 0 && cnt[p] == len[p])
        nl(p, 1'b0);
      push(p, c);
      cnt[p]++;
    end
    slow <= 1'($random(seed));
    apb(1'b1, ADDR_DATA, {8'h00, el, 2'h0, k, 1'b0, s, c});
  endtask : send

  task automatic ctrl(input logic [4:0] v);
    if (v[4]) begin
      cnt = '{0, 0, 0};
      ln = 0;
      q = 1'b0;
    end
    if (v[0])
      q = 1'b1;
    if (q && (v[2] || (v[1] && v[3]))) begin
      nl(2, 1'b1);
      q = 1'b0;
    end
    apb(1'b1, ADDR_CTRL, {27'h0, v});
  endtask : ctrl

  // wait for the predicted bytes, allow stragglers, then compare all
  task automatic drain;
    int n;
    n = 0;
    while (got.size() < want.size() && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      n_errors++;
      end_of_test();
    end
    repeat (60) @(posedge ref_clk);
    chk(got.size(), want.size());
    foreach (want[i]) chk(got[i], want[i]);
    got.delete();
    want.delete();
  endtask : drain

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int p = 0; p < 3; p++) begin
      apb(1'b0, 8'(4 * p), 32'h0);
      chk(rd, 32'h0005_0040);
    end
    // unmapped offset
    apb(1'b0, 8'h22, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    // all three at once, then console alone; the others keep 80
    apb(1'b1, ADDR_SEL_MULTI, 32'h0733_0250);
    sel(2, 8'h33, 4'h2, 8'h4B);
    for (int p = 0; p < 2; p++) begin
      apb(1'b0, 8'(4 * p), 32'h0);
      chk(rd, 32'h0033_0250);
    end
    sel(0, 8'h5A, 4'h2, 8'h40);
    sel(0, 8'h11, 4'h2, 8'h40);
    // length 5 filled exactly, no auto return, under device types 2, 4 and 0
    foreach (tl[j]) begin
      sel(1, 8'h22, tl[j], 8'h05);
      for (int i = 0; i < 8; i++) send(3'h0, 2'h0, pick(i), 8'h00);
      // ignored kind is held until the engine is idle, so the last count has landed
      send(3'h0, 2'h3, 8'h00, 8'h00);
      apb(1'b0, ADDR_COUNT, 32'h0);
      chk(rd, {8'h00, 8'(cnt[2]), 8'(cnt[1]), 8'(cnt[0])});
      send(3'h0, 2'h1, 8'h00, 8'h00);
      drain();
    end
    // zoned elements: exact fit, one over, at line start
    sel(1, 8'h22, 4'h2, 8'h00);
    for (int i = 0; i < 3; i++) send(3'h0, 2'h0, 8'h41, 8'h00);
    send(3'h0, 2'h2, 8'h00, 8'h0D);
    send(3'h0, 2'h2, 8'h00, 8'h0E);
    send(3'h0, 2'h2, 8'h00, 8'h14);
    drain();
    // every source, routed by purpose
    for (int s = 0; s < 5; s++) send(3'(s), 2'h0, 8'h41, 8'h00);
    drain();
    // queued return: step completion, program end, nothing queued
    ctrl(5'h01);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    ctrl(5'h02);
    ctrl(5'h0A);
    ctrl(5'h05);
    ctrl(5'h0A);
    drain();
    // seventeen console lines force two rolls
    ctrl(5'h10);
    sel(2, 8'h33, 4'h2, 8'h40);
    for (int i = 0; i < 17; i++) send(3'h4, 2'h1, 8'h00, 8'h00);
    drain();
    chk(rolls, erolls);
    end_of_test();
  end
endmodule : testbench
